// File: rtl/ppm_pkg.sv
// constants, types and carriers of the protection priority and mode logic
// assumes one 25 MHz clock, a synchronous active-high reset and an APB master
//
// What this block does
// - three trip divisions feed two independent voting and actuation divisions
// - each of the four trip functions votes two-out-of-three, or one-out-of-two when selected; high flux always votes two-out-of-three
// - automatic and manual safety actuation override nonsafety commands on every output
// - with nonsafety enable inactive every nonsafety command is ignored
// - enabled nonsafety command drives addressed output when no safety actuation present
// - command carries address and mirrored complement; only a consistent pair acts
// - nonsafety enable gates the whole parallel command interface into priority logic
// - new mode taken only on mode input rising edge or limit lockout; steady level keeps mode
// - on rising edge mode advances only if current mode permissives hold
// - limits violated after a transition: actuate, force mode 3, ignore mode input
// - actuation divisions A and B each have their own mode input
// - each division processes its own inputs before sharing results for voting
// - monitoring-only variables go only to the monitoring register path
// - each of three divisions has its own display path
// - enabled nonsafety commands may energize or de-energize any interface output
// - mode 0 to 1 needs dump and fill valves closed and flow above minimum
// - cell safety actuation when two of three high flux trips are active in mode 0 or 1
package ppm_pkg;

  timeunit 1ns;
  timeprecision 1ns;

  localparam int NDIV = 3;
  localparam int NACT = 2;
  localparam int NF = 4;
  localparam int NOUT = 8;
  localparam int AW = $clog2(NOUT) + 1;
  localparam int MON_W = 8;
  localparam int SYNC_W = 2;

  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h00c;
  localparam logic [11:0] OFF_MON = 12'h010;
  localparam logic [11:0] OFF_OUTS = 12'h014;

  localparam logic [NF-1:0] CTRL_RST = 4'h0;
  localparam logic [NOUT-1:0] SAFE_OUT = 8'h00;

  localparam int EV_ADV = 0;
  localparam int EV_REFUSE = 1;
  localparam int EV_LOCK = 2;
  localparam int EV_ACT = 3;
  localparam int EV_BADCMD = 4;
  localparam int EV_W = 5;
  localparam logic [EV_W-1:0] IMASK_RST = 5'h00;

  typedef enum logic [4:0] {
    MODE_0 = 5'h01,
    MODE_1 = 5'h02,
    MODE_2 = 5'h04,
    MODE_3 = 5'h08,
    MODE_4 = 5'h10
  } ppm_mode_t;

  typedef struct packed {
    logic [NDIV-1:0][NF-1:0] trip;
    logic [NDIV-1:0] flux_hi;
    logic [NACT-1:0] manual;
    logic [NACT-1:0] ns_en;
    logic [NACT-1:0] mode_req;
    logic dump_closed;
    logic fill_closed;
    logic flow_ok;
    logic [2:0] perm;
    logic limits_ok;
    logic ns_strobe;
    logic [AW-1:0] ns_addr;
    logic [AW-1:0] ns_addr_n;
    logic [MON_W-1:0] mon;
  } ppm_pins_t;

  typedef struct packed {
    ppm_mode_t mode;
    logic req_q;
    logic chk;
    logic lock;
    logic act;
    logic [NOUT-1:0] ns;
    logic [NOUT-1:0] equipment_interface_module;
  } ppm_div_t;

endpackage

// File: rtl/ppm_sync.sv
// two-flop synchroniser for a bundle of asynchronous pins
// assumes the bits are independent levels; no word coherence is promised
module ppm_sync import ppm_pkg::*; #(
  parameter int W = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ppm_sync_t;

  ppm_sync_t sync_reg;
  ppm_sync_t sync_next;

  always_comb begin
    sync_next.s1 = d_i;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q_o = sync_reg.s2;

endmodule

// File: rtl/ppm_vote.sv
// per-function channel voter of one actuation division
// assumes channel inputs are already synchronised
module ppm_vote import ppm_pkg::*; #(
  parameter int N = 4
) (
  input wire logic [NDIV-1:0][N-1:0] trip_i,
  input wire logic [N-1:0] sel_1oo2_i,
  output logic [N-1:0] vote_o
);

  timeunit 1ns;
  timeprecision 1ns;

  genvar k;
  generate
    for (k = 0; k < N; k++) begin : g_fn
      logic maj;
      assign maj = (trip_i[0][k] & trip_i[1][k]) |
                   (trip_i[0][k] & trip_i[2][k]) |
                   (trip_i[1][k] & trip_i[2][k]);
      // one-out-of-two uses channels a and b only
      assign vote_o[k] = sel_1oo2_i[k] ? (trip_i[0][k] | trip_i[1][k]) :
                                         maj;
    end
  endgenerate

endmodule

// File: rtl/ppm_top.sv
// voting, actuation priority and mode logic of the two actuation divisions
// assumes all field and controller pins are asynchronous, apb is on sys_clk_i
module ppm_top import ppm_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [NDIV-1:0][NF-1:0] trip_i,
  input wire logic [NDIV-1:0] flux_hi_i,
  input wire logic [NACT-1:0] manual_act_i,
  input wire logic [NACT-1:0] ns_enable_i,
  input wire logic [NACT-1:0] mode_req_i,
  input wire logic dump_closed_i,
  input wire logic fill_closed_i,
  input wire logic flow_ok_i,
  input wire logic [2:0] mode_perm_i,
  input wire logic limits_ok_i,
  input wire logic ns_strobe_i,
  input wire logic [AW-1:0] ns_addr_i,
  input wire logic [AW-1:0] ns_addr_n_i,
  input wire logic [MON_W-1:0] mon_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [NACT-1:0][NOUT-1:0] eim_o,
  output logic [NACT-1:0] act_o,
  output logic [NACT-1:0][4:0] mode_o,
  output logic [NACT-1:0] lock_o,
  output logic [NDIV-1:0][NF-1:0] disp_o,
  output logic irq_o
);

  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    ppm_div_t [NACT-1:0] div;
    logic strobe_q;
    logic [NF-1:0] vote_1oo2;
    logic [EV_W-1:0] ist;
    logic [EV_W-1:0] imask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [NDIV-1:0][NF-1:0] disp;
  } ppm_state_t;

  ppm_state_t st_reg;
  ppm_state_t st_next;
  ppm_pins_t raw;
  ppm_pins_t pin;
  logic [NACT-1:0][NF-1:0] fn_vote;
  logic [NACT-1:0][0:0] flux_vote;

  // every field and controller pin crosses two flops before any logic looks at it
  assign raw.trip = trip_i;
  assign raw.flux_hi = flux_hi_i;
  assign raw.manual = manual_act_i;
  assign raw.ns_en = ns_enable_i;
  assign raw.mode_req = mode_req_i;
  assign raw.dump_closed = dump_closed_i;
  assign raw.fill_closed = fill_closed_i;
  assign raw.flow_ok = flow_ok_i;
  assign raw.perm = mode_perm_i;
  assign raw.limits_ok = limits_ok_i;
  assign raw.ns_strobe = ns_strobe_i;
  assign raw.ns_addr = ns_addr_i;
  assign raw.ns_addr_n = ns_addr_n_i;
  assign raw.mon = mon_i;

  ppm_sync #(
    .W($bits(ppm_pins_t))
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .d_i(raw),
    .q_o(pin)
  );

  // each actuation division votes the three trip channels on its own
  genvar d;
  generate
    for (d = 0; d < NACT; d++) begin : g_act
      ppm_vote #(
        .N(NF)
      ) u_fn_vote (
        .trip_i(pin.trip),
        .sel_1oo2_i(st_reg.vote_1oo2),
        .vote_o(fn_vote[d])
      );
      logic [NDIV-1:0][0:0] flux_ch;
      assign flux_ch[0][0] = pin.flux_hi[0];
      assign flux_ch[1][0] = pin.flux_hi[1];
      assign flux_ch[2][0] = pin.flux_hi[2];
      ppm_vote #(
        .N(1)
      ) u_flux_vote (
        .trip_i(flux_ch),
        .sel_1oo2_i(1'b0),
        .vote_o(flux_vote[d])
      );
    end
  endgenerate

  // fixed sequence, one step per accepted edge; mode 4 wraps to mode 0
  function automatic ppm_mode_t step_mode(input ppm_mode_t m);
    unique case (m)
      MODE_0: step_mode = MODE_1;
      MODE_1: step_mode = MODE_2;
      MODE_2: step_mode = MODE_3;
      MODE_3: step_mode = MODE_4;
      MODE_4: step_mode = MODE_0;
      default: step_mode = MODE_3;
    endcase
  endfunction

  function automatic logic perm_ok(input ppm_mode_t m, input ppm_pins_t p);
    unique case (m)
      MODE_0: perm_ok = p.dump_closed & p.fill_closed & p.flow_ok;
      MODE_1: perm_ok = p.fill_closed;
      MODE_2: perm_ok = p.perm[0];
      MODE_3: perm_ok = p.perm[1];
      MODE_4: perm_ok = p.perm[2];
      default: perm_ok = 1'b0;
    endcase
  endfunction

  // high flux actuation is only armed while filling can happen
  function automatic logic flux_armed(input ppm_mode_t m);
    flux_armed = (m == MODE_0) || (m == MODE_1);
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == OFF_CTRL) || (a == OFF_STATUS) ||
                (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK) ||
                (a == OFF_MON) || (a == OFF_OUTS);
  endfunction

  function automatic logic [15:0] status_word(input ppm_state_t s);
    status_word = {2'h0, s.div[1].act, s.div[0].act,
                   s.div[1].lock, s.div[0].lock,
                   s.div[1].mode, s.div[0].mode};
  endfunction

  // reads have no side effect here; the status clear happens at completion
  function automatic logic [31:0] read_word(input logic [11:0] a,
                                            input ppm_state_t s,
                                            input logic [MON_W-1:0] mon);
    logic [31:0] w;
    w = '0;
    unique case (a)
      OFF_CTRL: w[NF-1:0] = s.vote_1oo2;
      OFF_STATUS: w[15:0] = status_word(s);
      OFF_IRQ_STAT: w[EV_W-1:0] = s.ist;
      OFF_IRQ_MASK: w[EV_W-1:0] = s.imask;
      // monitoring-only values are visible here and feed no safety path
      OFF_MON: w[MON_W-1:0] = mon;
      OFF_OUTS: w[15:0] = {s.div[1].equipment_interface_module, s.div[0].equipment_interface_module};
      default: w = '0;
    endcase
    read_word = w;
  endfunction

  always_comb begin
    logic strobe_rise;
    logic pair_ok;
    logic rise;
    logic auto_act;
    logic acc;
    logic done;
    logic [AW-2:0] idx;
    logic [EV_W-1:0] ev;
    strobe_rise = 1'b0;
    pair_ok = 1'b0;
    rise = 1'b0;
    auto_act = 1'b0;
    acc = 1'b0;
    done = 1'b0;
    idx = '0;
    ev = '0;
    st_next = st_reg;

    st_next.strobe_q = pin.ns_strobe;
    strobe_rise = pin.ns_strobe & ~st_reg.strobe_q;
    pair_ok = (pin.ns_addr == ~pin.ns_addr_n);
    idx = pin.ns_addr[AW-2:0];

    for (int i = 0; i < NACT; i++) begin
      // own mode input per division
      st_next.div[i].req_q = pin.mode_req[i];
      rise = pin.mode_req[i] & ~st_reg.div[i].req_q;
      if (st_reg.div[i].lock) begin
        // locked out: mode input no longer matters
        st_next.div[i].mode = MODE_3;
      end else if (st_reg.div[i].chk) begin
        st_next.div[i].chk = 1'b0;
        if (!pin.limits_ok) begin
          st_next.div[i].lock = 1'b1;
          st_next.div[i].mode = MODE_3;
          ev[EV_LOCK] = 1'b1;
        end
      end else if (rise) begin
        if (perm_ok(st_reg.div[i].mode, pin)) begin
          st_next.div[i].mode = step_mode(st_reg.div[i].mode);
          st_next.div[i].chk = 1'b1;
          ev[EV_ADV] = 1'b1;
        end else begin
          ev[EV_REFUSE] = 1'b1;
        end
      end

      auto_act = (|fn_vote[i]) | st_reg.div[i].lock |
                 (flux_vote[i][0] & flux_armed(st_reg.div[i].mode));
      st_next.div[i].act = auto_act | pin.manual[i];
      if (st_next.div[i].act && !st_reg.div[i].act) begin
        ev[EV_ACT] = 1'b1;
      end

      // command path only open while this division's enable is on
      if (strobe_rise && pin.ns_en[i]) begin
        if (pair_ok) begin
          st_next.div[i].ns[idx] = pin.ns_addr[AW-1];
        end else begin
          ev[EV_BADCMD] = 1'b1;
        end
      end

      // safety actuation wins over anything nonsafety has set
      if (st_next.div[i].act) begin
        st_next.div[i].equipment_interface_module = SAFE_OUT;
      end else begin
        st_next.div[i].equipment_interface_module = st_next.div[i].ns;
      end
    end

    // each trip division reaches the display on its own lanes
    st_next.disp = pin.trip;

    // apb: one wait state, answer registered with pready
    acc = psel_i & penable_i;
    done = acc & st_reg.pready;
    st_next.pready = acc & ~st_reg.pready;
    if (acc && !st_reg.pready) begin
      st_next.pslverr = ~is_mapped(paddr_i);
      st_next.prdata = '0;
      if (!pwrite_i) begin
        st_next.prdata = read_word(paddr_i, st_reg, pin.mon);
      end
    end else begin
      // the error flag stands only in the cycle in which pready is high
      st_next.pslverr = 1'b0;
    end

    if (done && pwrite_i && pstrb_i[0]) begin
      if (paddr_i == OFF_CTRL) begin
        st_next.vote_1oo2 = pwdata_i[NF-1:0];
      end
      if (paddr_i == OFF_IRQ_MASK) begin
        st_next.imask = pwdata_i[EV_W-1:0];
      end
    end

    // read clears, but a same-cycle event still lands
    if (done && !pwrite_i && paddr_i == OFF_IRQ_STAT) begin
      st_next.ist = '0;
    end
    st_next.ist = st_next.ist | ev;
    st_next.irq = |(st_next.ist & st_next.imask);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NACT; i++) begin
        st_reg.div[i].mode <= MODE_0;
        st_reg.div[i].req_q <= 1'b0;
        st_reg.div[i].chk <= 1'b0;
        st_reg.div[i].lock <= 1'b0;
        st_reg.div[i].act <= 1'b0;
        st_reg.div[i].ns <= SAFE_OUT;
        st_reg.div[i].equipment_interface_module <= SAFE_OUT;
      end
      st_reg.strobe_q <= 1'b0;
      st_reg.vote_1oo2 <= CTRL_RST;
      st_reg.ist <= '0;
      st_reg.imask <= IMASK_RST;
      st_reg.irq <= 1'b0;
      st_reg.pready <= 1'b0;
      st_reg.pslverr <= 1'b0;
      st_reg.prdata <= '0;
      st_reg.disp <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    for (int i = 0; i < NACT; i++) begin
      eim_o[i] = st_reg.div[i].equipment_interface_module;
      act_o[i] = st_reg.div[i].act;
      mode_o[i] = st_reg.div[i].mode;
      lock_o[i] = st_reg.div[i].lock;
    end
  end

  assign prdata_o = st_reg.prdata;
  assign pready_o = st_reg.pready;
  assign pslverr_o = st_reg.pslverr;
  assign disp_o = st_reg.disp;
  assign irq_o = st_reg.irq;

endmodule

// File: tb/ppm_checker.sv
// port assertions for ppm_top, bound below
// assumes one clock domain and a synchronous active-high reset
module ppm_checker import ppm_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [NDIV-1:0][NF-1:0] trip_i,
  input wire logic [NDIV-1:0] flux_hi_i,
  input wire logic [NACT-1:0] manual_act_i,
  input wire logic [NACT-1:0] ns_enable_i,
  input wire logic [NACT-1:0] mode_req_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic [NACT-1:0][NOUT-1:0] eim_o,
  input wire logic [NACT-1:0] act_o,
  input wire logic [NACT-1:0][4:0] mode_o,
  input wire logic [NACT-1:0] lock_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  logic [4:0] mode_prev;
  always_ff @(posedge sys_clk_i) begin
    mode_prev <= mode_o[0];
  end
  act_clear_a: assert property ((act_o[0] -> eim_o[0] == 8'h00) &&
    (act_o[1] -> eim_o[1] == 8'h00)) else $error("eim driven in actuation");
  manual_act_a: assert property (manual_act_i[0] [*4] |-> act_o[0])
    else $error("manual actuation missed");
  trip_vote_a: assert property ((trip_i[0][1] && trip_i[1][1]) [*4]
    |-> act_o == 2'b11) else $error("two of three trips missed");
  flux_vote_a: assert property ((flux_hi_i[0] && flux_hi_i[2])
    [*4] ##0 mode_o[1] == 5'h01 |-> act_o[1])
    else $error("flux vote missed");
  ns_gate_a: assert property ((!ns_enable_i[0]) [*4] ##0
    (!act_o[0] && !$past(act_o[0])) |-> $stable(eim_o[0]))
    else $error("eim moved while disabled");
  lock_keep_a: assert property (lock_o[0] |=>
    lock_o[0] && mode_o[0] == 5'h08) else $error("lockout lost");
  lock_act_a: assert property ($rose(lock_o[0]) |=> act_o[0])
    else $error("lockout without actuation");
  mode_step_a: assert property (mode_o[0] != mode_prev |->
    mode_o[0] == 5'h08 || mode_o[0] == {mode_prev[3:0], mode_prev[4]})
    else $error("mode skipped a step");
  mode_edge_a: assert property ($changed(mode_o[0]) && !lock_o[0]
    |-> $past(mode_req_i[0], 3)) else $error("mode moved without edge");
  apb_wait_a: assert property ($rose(penable_i) && psel_i |->
    !pready_o ##1 pready_o) else $error("apb answer late");
endmodule
bind ppm_top ppm_checker chk_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .trip_i(trip_i), .flux_hi_i(flux_hi_i), .manual_act_i(manual_act_i),
  .ns_enable_i(ns_enable_i), .mode_req_i(mode_req_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .eim_o(eim_o),
  .act_o(act_o), .mode_o(mode_o), .lock_o(lock_o));

// File: tb/ppm_plant.sv
// plant controller model: command pairs and discrete mode pulses
// assumes the block samples these pins through synchronisers
module ppm_plant import ppm_pkg::*; (
  input wire logic sys_clk_i,
  output logic ns_strobe_o,
  output logic [AW-1:0] ns_addr_o,
  output logic [AW-1:0] ns_addr_n_o,
  output logic [NACT-1:0] mode_req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ns_strobe_o = 1'b0;
    ns_addr_o = 4'h0;
    ns_addr_n_o = 4'hf;
    mode_req_o = 2'b00;
  end
  task send(input logic st, input logic [2:0] idx, input logic bad);
    @(posedge sys_clk_i);
    ns_addr_o <= {st, idx};
    ns_addr_n_o <= ~{st, idx} ^ {3'h0, bad};
    @(posedge sys_clk_i);
    ns_strobe_o <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    ns_strobe_o <= 1'b0;
    @(posedge sys_clk_i);
    // idle lines flip so a stale pair never reads as a held value
    ns_addr_o <= ~ns_addr_o;
    ns_addr_n_o <= ~ns_addr_n_o;
    @(posedge sys_clk_i);
    #1;
  endtask
  task pulse(input int d, input int n);
    @(posedge sys_clk_i);
    mode_req_o[d] <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
    mode_req_o[d] <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask
endmodule

// File: tb/tb.sv
// self-checking bench for ppm_top with the plant controller model
// assumes ppm_plant drives the command and mode pins
module tb import ppm_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [NDIV-1:0][NF-1:0] trip = '0;
  logic [NDIV-1:0] flux = '0;
  logic [NACT-1:0] man = '0;
  logic [NACT-1:0] nsen = '0;
  logic flow = 1'b0;
  logic dump = 1'b1;
  logic fill = 1'b1;
  logic [2:0] perm = 3'h0;
  logic lim = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] pad = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic strobe, prdy, perr, irq, e;
  logic [AW-1:0] addr, addr_n;
  logic [NACT-1:0] mreq, act, lock;
  logic [31:0] prd, r;
  logic [NACT-1:0][NOUT-1:0] equipment_interface_module;
  logic [NACT-1:0][4:0] mode;
  logic [NDIV-1:0][NF-1:0] disp;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  ppm_plant plant (.sys_clk_i(clk), .ns_strobe_o(strobe),
    .ns_addr_o(addr), .ns_addr_n_o(addr_n), .mode_req_o(mreq));
  ppm_top DUT (.sys_clk_i(clk), .rst_i(rst), .trip_i(trip),
    .flux_hi_i(flux), .manual_act_i(man), .ns_enable_i(nsen),
    .mode_req_i(mreq), .dump_closed_i(dump), .fill_closed_i(fill),
    .flow_ok_i(flow), .mode_perm_i(perm), .limits_ok_i(lim),
    .ns_strobe_i(strobe), .ns_addr_i(addr), .ns_addr_n_i(addr_n),
    .mon_i(8'h5a), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pad), .pwdata_i(pwd), .pstrb_i(4'hf), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .eim_o(equipment_interface_module), .act_o(act),
    .mode_o(mode), .lock_o(lock), .disp_o(disp), .irq_o(irq));
  task conclude;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      conclude();
    end
  end
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, x, g);
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    pad <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, x, r);
  endtask
  task t_reset;
    chk("mode", {5'h01, 5'h01}, mode);
    chk("outs", 32'h0, {equipment_interface_module, act, lock, irq});
    rd(OFF_CTRL, 32'h0, "ctrl");
    rd(OFF_IRQ_MASK, 32'h0, "mask");
    rd(OFF_STATUS, 32'h21, "status");
    rd(OFF_MON, 32'h5a, "mon");
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", 32'h1, {r[30:0], e});
    apb(1'b1, OFF_IRQ_MASK, 32'h1f);
    rd(OFF_IRQ_MASK, 32'h1f, "mask wr");
  endtask
  task t_cmd;
    @(posedge clk);
    nsen <= 2'b11;
    w(4);
    plant.send(1'b1, 3'd3, 1'b0);
    chk("eim on", {8'h08, 8'h08}, equipment_interface_module);
    rd(OFF_OUTS, 32'h0808, "outs reg");
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    plant.send(1'b0, 3'd3, 1'b1);
    chk("eim bad", {8'h08, 8'h08}, equipment_interface_module);
    chk("irq bad", 32'h1, irq);
    rd(OFF_IRQ_STAT, 32'h10, "stat bad");
    w(3);
    chk("irq clr", 32'h0, irq);
    plant.send(1'b0, 3'd3, 1'b0);
    chk("eim off", 32'h0, equipment_interface_module);
    plant.send(1'b1, 3'd7, 1'b0);
    @(posedge clk);
    nsen <= 2'b00;
    w(4);
    plant.send(1'b1, 3'd0, 1'b0);
    chk("eim gated", {8'h80, 8'h80}, equipment_interface_module);
  endtask
  task t_prio;
    @(posedge clk);
    nsen <= 2'b11;
    man <= 2'b01;
    w(5);
    plant.send(1'b1, 3'd1, 1'b0);
    chk("act man", 32'h1, act);
    chk("eim prio", {8'h82, 8'h00}, equipment_interface_module);
    @(posedge clk);
    man <= 2'b00;
    w(5);
    chk("act off", 32'h0, act);
    chk("eim back", {8'h82, 8'h82}, equipment_interface_module);
  endtask
  task t_vote;
    @(posedge clk);
    trip <= 12'h022;
    w(5);
    chk("act 2of3", 32'h3, act);
    @(posedge clk);
    trip <= 12'h400;
    w(5);
    chk("act 1of3", 32'h0, act);
    chk("disp", 32'h400, disp);
    apb(1'b1, OFF_CTRL, 32'h1);
    @(posedge clk);
    trip <= 12'h001;
    w(5);
    chk("act 1of2", 32'h3, act);
    apb(1'b1, OFF_CTRL, 32'h0);
    w(5);
    chk("act ctrl0", 32'h0, act);
    @(posedge clk);
    trip <= '0;
    flux <= 3'b101;
    w(5);
    chk("act flux", 32'h3, act);
    @(posedge clk);
    flux <= 3'b001;
    w(5);
    chk("flux one", 32'h0, act);
  endtask
  task t_mode;
    apb(1'b1, OFF_IRQ_MASK, 32'h1d);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    w(3);
    plant.pulse(0, 4);
    chk("refused", {5'h01, 5'h01}, mode);
    chk("irq mask", 32'h0, irq);
    rd(OFF_IRQ_STAT, 32'h2, "stat ref");
    @(posedge clk);
    flow <= 1'b1;
    dump <= 1'b0;
    plant.pulse(0, 4);
    chk("dump open", {5'h01, 5'h01}, mode);
    @(posedge clk);
    dump <= 1'b1;
    fill <= 1'b0;
    plant.pulse(0, 4);
    chk("fill open", {5'h01, 5'h01}, mode);
    @(posedge clk);
    fill <= 1'b1;
    perm <= 3'h7;
    for (int i = 1; i <= 5; i++) begin
      plant.pulse(1, 4);
      chk("mode b", 32'h1 << (i % 5), mode[1]);
    end
    plant.pulse(0, 30);
    chk("held", {5'h01, 5'h02}, mode);
    @(posedge clk);
    lim <= 1'b0;
    plant.pulse(0, 4);
    chk("lock", 32'h1, lock);
    plant.pulse(0, 4);
    rd(OFF_STATUS, 32'h1428, "st lock");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    w(3);
    t_reset();
    t_cmd();
    t_prio();
    t_vote();
    t_mode();
    conclude();
  end
endmodule
